// ===== usb_se0_params.svh
// timing figures, register indices and field positions of the se0 classifier
`ifndef USB_SE0_PARAMS_SVH
`define USB_SE0_PARAMS_SVH

// clock period and se0 width borders
`define CLK_NS 20
`define SE0_SHORT_NS 500
`define SE0_RST_NS 2670
`define SE0_SHORT_CYC ((`SE0_SHORT_NS + `CLK_NS - 1) / `CLK_NS)
`define SE0_RST_CYC ((`SE0_RST_NS + `CLK_NS - 1) / `CLK_NS)

// wait for eop after token or data bits, and bus idle time to suspend
`define EOP_TO_NS 10000
`define EOP_TO_CYC (`EOP_TO_NS / `CLK_NS)
`define SUSP_NS 3000000
`define SUSP_CYC (`SUSP_NS / `CLK_NS)

// register indices, byte address is four times the index
`define ADDR_W 12
`define IDX_STATUS 8'h19
`define IDX_CTRL 8'h1a
`define IDX_TOKEN 8'h1f
`define IDX_IEN 8'h20
`define IDX_ISTAT 8'h21
`define IDX_IMASK 8'h22

// field positions and values
`define BIT_EOP 0
`define BIT_FEOP 2
`define BIT_TOKEN_RECEIVED_FLAG 7
`define BIT_TOKEN_IRQ_ENABLE 6
`define BIT_RESUME_IRQ_ENABLE 5
`define BIT_BUS_RESET_IRQ_ENABLE 4
`define MODE_HI 7
`define MODE_LO 6
`define MODE_USB 2'b11
`define CTRL_RST 8'h00

// interrupt status and mask layout
`define IRQ_W 6
`define IRQ_IN 0
`define IRQ_OUT 1
`define IRQ_RST 2
`define IRQ_SUSP 3
`define IRQ_RSM 4
`define IRQ_FEOP 5

// axi responses
`define RESP_OKAY 2'b00
`define RESP_SLVERR 2'b10

`endif

// ===== usb_se0_pkg.sv
// types shared by the se0 classifier modules
package usb_se0_pkg;
   typedef enum logic [3:0] {
      ST_IDLE = 4'b0001,
      ST_TOKEN = 4'b0010,
      ST_DATA = 4'b0100,
      ST_SUSP = 4'b1000
   } link_state_e;
   typedef logic [7:0] se0_width_t;
   typedef logic [7:0] reg_byte_t;
endpackage : usb_se0_pkg

// ===== se0_timer.sv
// measures the width of each se0 run on the bus
`timescale 1ns/1ps
`include "usb_se0_params.svh"
module se0_timer
   import usb_se0_pkg::*;
(
   input wire logic clk,
   input wire logic rst_n,
   input wire logic clk_en,
   input wire logic se0,
   output se0_width_t width,
   output logic se0_end,
   output logic reset_hit
);
   se0_width_t cnt;
   logic se0_d;

   // saturating run length and threshold hit
   wire sat = &cnt;
   wire hit = se0 && (cnt == 8'(`SE0_RST_CYC - 1));
   wire falling = !se0 && se0_d;

   // count while se0, latch the width when it ends
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         cnt <= 8'h00;
         se0_d <= 1'b0;
         width <= 8'h00;
         se0_end <= 1'b0;
         reset_hit <= 1'b0;
      end else if (clk_en) begin
         se0_d <= se0;
         reset_hit <= hit;
         se0_end <= falling;
         if (falling) begin
            width <= cnt;
         end
         if (se0) begin
            if (!sat) begin
               cnt <= cnt + 8'h01;
            end
         end else begin
            cnt <= 8'h00;
         end
      end
   end
endmodule : se0_timer

// ===== usb_se0_width_classifier.sv
// low-speed usb se0 width classifier with axi4-lite registers
//
// How it works
// - every se0 is timed and sorted by fixed width borders.
// - idle se0 under 0.5 us ignored; suspend timer keeps counting.
// - short se0 after packet is no eop; timeout returns idle, flags error.
// - idle se0 of 0.5 to 2.67 us is keep-alive, restarts suspend timer.
// - mid se0 after token is eop and raises token interrupt.
// - mid se0 after data or handshake sets eop flag, no interrupt.
// - se0 of 2.5 to 2.67 us still counts as mid and raises reset only in suspend.
// - token received flag sits at bit 7 of index 0x1f.
// - se0 of 2.67 us or more raises bus reset outside suspend.
// - token enable bit 6 of 0x20 set while a token is expected.
// - resume enable bit 5 of 0x20 set only in suspend.
// - reset enable bit 4 of 0x20 set outside suspend.
// - false eop flag at bit 2 of 0x19 set on failed eop.
// - usb logic runs only with mode bits 7 and 6 at 11.
// - six interrupt sources: in token, out token, reset, suspend, resume, false eop.
`timescale 1ns/1ps
`include "usb_se0_params.svh"
module usb_se0_width_classifier
   import usb_se0_pkg::*;
#(
   parameter int unsigned SUSP_CYCLES = `SUSP_CYC
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic clk_en,
   input wire logic se0,
   input wire logic rx_active,
   input wire logic token_end,
   input wire logic token_dir_in,
   input wire logic data_end,
   input wire logic [`ADDR_W-1:0] awaddr,
   input wire logic awvalid,
   output logic awready,
   input wire logic [31:0] wdata,
   input wire logic [3:0] wstrb,
   input wire logic wvalid,
   output logic wready,
   output logic [1:0] bresp,
   output logic bvalid,
   input wire logic bready,
   input wire logic [`ADDR_W-1:0] araddr,
   input wire logic arvalid,
   output logic arready,
   output logic [31:0] rdata,
   output logic [1:0] rresp,
   output logic rvalid,
   input wire logic rready,
   output logic irq
);
   localparam logic [17:0] SUSP_LAST = 18'(SUSP_CYCLES - 1);
   localparam logic [9:0] TO_LAST = 10'(`EOP_TO_CYC - 1);

   // register index of a byte address, upper bits must be zero
   function automatic logic [7:0] reg_idx(input logic [`ADDR_W-1:0] a);
      return a[9:2];
   endfunction : reg_idx

   // true when the address hits a register
   function automatic logic mapped(input logic [`ADDR_W-1:0] a);
      logic [7:0] i;
      i = reg_idx(a);
      return (a[11:10] == 2'b00) && ((i == `IDX_STATUS) || (i == `IDX_CTRL) ||
         (i == `IDX_TOKEN) || (i == `IDX_IEN) || (i == `IDX_ISTAT) ||
         (i == `IDX_IMASK));
   endfunction : mapped

   // true when a width is below the eop border
   function automatic logic is_short(input se0_width_t w);
      return w < 8'(`SE0_SHORT_CYC);
   endfunction : is_short

   link_state_e state;
   link_state_e next_state;
   se0_width_t width;
   logic se0_end;
   logic reset_hit;
   logic [17:0] susp_cnt;
   logic [9:0] to_cnt;
   logic token_in;
   reg_byte_t ctrl;
   logic eop_flag;
   logic feop_flag;
   logic token_flag;
   logic [`IRQ_W-1:0] istat;
   logic [`IRQ_W-1:0] imask;
   logic ev_tok;
   logic ev_eop;
   logic ev_rst;
   logic ev_susp;
   logic ev_rsm;
   logic ev_feop;
   logic keep_alive;

   // se0 width measurement
   se0_timer u_timer (
      .clk(clk),
      .rst_n(rst_n),
      .clk_en(clk_en),
      .se0(se0),
      .width(width),
      .se0_end(se0_end),
      .reset_hit(reset_hit)
   );

   // width classes of a finished se0
   wire usb_on = ({ctrl[`MODE_HI], ctrl[`MODE_LO]} == `MODE_USB);
   wire ev_short = se0_end && is_short(width);
   wire ev_mid = se0_end && !is_short(width) && (width < 8'(`SE0_RST_CYC));
   wire susp_due = (susp_cnt == SUSP_LAST);
   wire to_due = (to_cnt == TO_LAST);

   // enable bits follow the state
   wire token_irq_enable = (state == ST_IDLE) || (state == ST_TOKEN);
   wire resume_irq_enable = (state == ST_SUSP);
   wire bus_reset_irq_enable = (state != ST_SUSP);

   // classification state machine
   always_comb begin
      next_state = state;
      ev_tok = 1'b0;
      ev_eop = 1'b0;
      ev_rst = 1'b0;
      ev_susp = 1'b0;
      ev_rsm = 1'b0;
      ev_feop = 1'b0;
      keep_alive = 1'b0;
      if (!usb_on) begin
         next_state = ST_IDLE;
      end else if (reset_hit && state != ST_SUSP) begin
         ev_rst = 1'b1;
         next_state = ST_IDLE;
      end else begin
         case (state)
            ST_IDLE: begin
               if (token_end) begin
                  next_state = ST_TOKEN;
               end else if (data_end) begin
                  next_state = ST_DATA;
               end else if (ev_mid) begin
                  keep_alive = 1'b1;
               end else if (susp_due) begin
                  ev_susp = 1'b1;
                  next_state = ST_SUSP;
               end
            end
            ST_TOKEN: begin
               if (ev_mid) begin
                  ev_tok = 1'b1;
                  next_state = ST_IDLE;
               end else if (to_due) begin
                  ev_feop = 1'b1;
                  next_state = ST_IDLE;
               end
            end
            ST_DATA: begin
               if (ev_mid) begin
                  ev_eop = 1'b1;
                  next_state = ST_IDLE;
               end else if (to_due) begin
                  ev_feop = 1'b1;
                  next_state = ST_IDLE;
               end
            end
            ST_SUSP: begin
               if (se0_end) begin
                  ev_rst = 1'b1;
                  next_state = ST_IDLE;
               end else if (rx_active) begin
                  ev_rsm = 1'b1;
                  next_state = ST_IDLE;
               end
            end
            default: begin
               next_state = ST_IDLE;
            end
         endcase
      end
   end

   // state, suspend timer and eop wait timer
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         state <= ST_IDLE;
         susp_cnt <= 18'h00000;
         to_cnt <= 10'h000;
         token_in <= 1'b0;
      end else if (clk_en) begin
         state <= next_state;
         if (token_end) begin
            token_in <= token_dir_in;
         end
         if (next_state != ST_IDLE || keep_alive || rx_active || !usb_on) begin
            susp_cnt <= 18'h00000;
         end else if (!susp_due) begin
            susp_cnt <= susp_cnt + 18'h00001;
         end
         if (next_state != state || state == ST_IDLE || state == ST_SUSP) begin
            to_cnt <= 10'h000;
         end else begin
            to_cnt <= to_cnt + 10'h001;
         end
      end
   end

   // axi write side
   logic aw_held;
   logic w_held;
   logic [`ADDR_W-1:0] aw_q;
   logic [31:0] wd_q;
   logic wlane_q;
   assign awready = !aw_held && !bvalid;
   assign wready = !w_held && !bvalid;
   wire wr_fire = aw_held && w_held && !bvalid;
   wire wr_ok = wr_fire && mapped(aw_q) && wlane_q;
   wire [7:0] wr_idx = reg_idx(aw_q);
   wire wr_status = wr_ok && (wr_idx == `IDX_STATUS);
   wire wr_ctrl = wr_ok && (wr_idx == `IDX_CTRL);
   wire wr_token = wr_ok && (wr_idx == `IDX_TOKEN);
   wire wr_istat = wr_ok && (wr_idx == `IDX_ISTAT);
   wire wr_imask = wr_ok && (wr_idx == `IDX_IMASK);

   // write handshake and response
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         aw_held <= 1'b0;
         w_held <= 1'b0;
         aw_q <= '0;
         wd_q <= 32'h00000000;
         wlane_q <= 1'b0;
         bvalid <= 1'b0;
         bresp <= `RESP_OKAY;
      end else if (clk_en) begin
         if (awvalid && awready) begin
            aw_held <= 1'b1;
            aw_q <= awaddr;
         end
         if (wvalid && wready) begin
            w_held <= 1'b1;
            wd_q <= wdata;
            wlane_q <= wstrb[0];
         end
         if (wr_fire) begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
            bvalid <= 1'b1;
            bresp <= mapped(aw_q) ? `RESP_OKAY : `RESP_SLVERR;
         end else if (bvalid && bready) begin
            bvalid <= 1'b0;
         end
      end
   end

   // interrupt events and write-one-to-clear masks
   wire [`IRQ_W-1:0] ev_vec = {ev_feop, ev_rsm, ev_susp, ev_rst,
      ev_tok && !token_in, ev_tok && token_in};
   wire [`IRQ_W-1:0] istat_clr = wr_istat ? wd_q[`IRQ_W-1:0] : '0;
   wire [`IRQ_W-1:0] next_istat = ev_vec | (istat & ~istat_clr);
   wire next_eop = ev_eop || (eop_flag && !(wr_status && wd_q[`BIT_EOP]));
   wire next_feop = ev_feop || (feop_flag && !(wr_status && wd_q[`BIT_FEOP]));
   wire next_token = ev_tok || (token_flag && !(wr_token && wd_q[`BIT_TOKEN_RECEIVED_FLAG]));

   // flags and software registers, a set beats a clear
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         ctrl <= `CTRL_RST;
         eop_flag <= 1'b0;
         feop_flag <= 1'b0;
         token_flag <= 1'b0;
         istat <= '0;
         imask <= '0;
      end else if (clk_en) begin
         eop_flag <= next_eop;
         feop_flag <= next_feop;
         token_flag <= next_token;
         istat <= next_istat;
         if (wr_ctrl) begin
            ctrl <= wd_q[7:0];
         end
         if (wr_imask) begin
            imask <= wd_q[`IRQ_W-1:0];
         end
      end
   end

   // level interrupt from unmasked status
   assign irq = |(istat & imask);

   // read data selection
   wire [7:0] rd_idx = reg_idx(araddr);
   logic [31:0] rd_word;
   always_comb begin
      rd_word = 32'h00000000;
      if (!mapped(araddr)) begin
         rd_word = 32'h00000000;
      end else if (rd_idx == `IDX_STATUS) begin
         rd_word[`BIT_EOP] = eop_flag;
         rd_word[`BIT_FEOP] = feop_flag;
      end else if (rd_idx == `IDX_CTRL) begin
         rd_word[7:0] = ctrl;
      end else if (rd_idx == `IDX_TOKEN) begin
         rd_word[`BIT_TOKEN_RECEIVED_FLAG] = token_flag;
      end else if (rd_idx == `IDX_IEN) begin
         rd_word[`BIT_TOKEN_IRQ_ENABLE] = token_irq_enable;
         rd_word[`BIT_RESUME_IRQ_ENABLE] = resume_irq_enable;
         rd_word[`BIT_BUS_RESET_IRQ_ENABLE] = bus_reset_irq_enable;
      end else if (rd_idx == `IDX_ISTAT) begin
         rd_word[`IRQ_W-1:0] = istat;
      end else begin
         rd_word[`IRQ_W-1:0] = imask;
      end
   end

   // read handshake
   assign arready = !rvalid;
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         rvalid <= 1'b0;
         rdata <= 32'h00000000;
         rresp <= `RESP_OKAY;
      end else if (clk_en) begin
         if (arvalid && arready) begin
            rvalid <= 1'b1;
            rdata <= rd_word;
            rresp <= mapped(araddr) ? `RESP_OKAY : `RESP_SLVERR;
         end else if (rvalid && rready) begin
            rvalid <= 1'b0;
         end
      end
   end

   // checks on the classification
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rst_n);

   wire quiet_idle = clk_en && usb_on && state == ST_IDLE && !reset_hit;

   a_short_idle_ignored: assert property (quiet_idle && ev_short && !token_end && !data_end
      && !rx_active && !susp_due |=> susp_cnt == $past(susp_cnt) + 18'h00001)
      else $error("short idle se0 disturbed suspend timer");
   a_keepalive_restart: assert property (quiet_idle && ev_mid && !token_end && !data_end
      |=> susp_cnt == 18'h00000 && state == ST_IDLE)
      else $error("keep-alive did not restart suspend timer");
   a_token_eop_irq: assert property (clk_en && usb_on && state == ST_TOKEN && ev_mid
      && !reset_hit |=> token_flag && (istat[`IRQ_IN] || istat[`IRQ_OUT])
      && state == ST_IDLE)
      else $error("token eop raised no token interrupt");
   a_data_eop_flag: assert property (clk_en && usb_on && state == ST_DATA && ev_mid
      && !reset_hit |=> eop_flag && $stable(istat[`IRQ_IN]) && state == ST_IDLE)
      else $error("data eop flag not set");
   a_feop_timeout: assert property (clk_en && usb_on && state == ST_TOKEN && to_due
      && !ev_mid && !reset_hit |=> feop_flag && istat[`IRQ_FEOP] && state == ST_IDLE)
      else $error("eop timeout did not flag false eop");
   a_long_se0_reset: assert property (clk_en && se0 ##1 (clk_en && se0)[*7] ##1 (reset_hit
      && clk_en && usb_on && state != ST_SUSP) |=> istat[`IRQ_RST] && state == ST_IDLE)
      else $error("long se0 raised no bus reset");
   a_suspend_se0_reset: assert property (clk_en && usb_on && state == ST_SUSP && se0_end
      |=> istat[`IRQ_RST] && state == ST_IDLE)
      else $error("se0 in suspend raised no reset");
   a_enable_bits: assert property (clk_en && usb_on && ev_susp
      |=> state == ST_SUSP && resume_irq_enable && !token_irq_enable && !bus_reset_irq_enable)
      else $error("enable bits disagree with suspend");
   a_mode_gate: assert property (clk_en && !usb_on |=> state == ST_IDLE
      && (istat & ~$past(istat)) == '0)
      else $error("usb logic active with mode off");
endmodule : usb_se0_width_classifier

// ===== usb_host_model.sv
// far-side low-speed host model: bus activity, packet end strobes and se0 runs
`timescale 1ns/1ps
module usb_host_model (
   input wire logic clk,
   output logic se0,
   output logic rx_active,
   output logic token_end,
   output logic token_dir_in,
   output logic data_end
);
   // bus rests in idle: no se0, no activity, no strobes
   initial begin
      se0 = 1'b0;
      rx_active = 1'b0;
      token_end = 1'b0;
      token_dir_in = 1'b0;
      data_end = 1'b0;
   end

   // kind 0 bare se0, 1 token, 2 data or handshake; se0 lasts w cycles
   task automatic packet(input int kind, input logic dir_in, input int w);
      if (kind != 0) begin
         rx_active <= 1'b1;
         repeat (8) @(posedge clk);
         rx_active <= 1'b0;
         token_end <= (kind == 1);
         data_end <= (kind == 2);
         token_dir_in <= dir_in;
         @(posedge clk);
         token_end <= 1'b0;
         data_end <= 1'b0;
         token_dir_in <= ~dir_in; // direction is only valid with the strobe
      end
      se0 <= 1'b1;
      repeat (w) @(posedge clk);
      se0 <= 1'b0;
      @(posedge clk);
   endtask : packet

   // resume signalling: bus activity with no packet
   task automatic activity(input int n);
      rx_active <= 1'b1;
      repeat (n) @(posedge clk);
      rx_active <= 1'b0;
      @(posedge clk);
   endtask : activity
endmodule : usb_host_model

// ===== usb_se0_width_classifier_bench.sv
// self-checking bench for the se0 width classifier
`timescale 1ns/1ps
`include "usb_se0_params.svh"
`define CHECK(g, e) check_val(32'(g), 32'(e))
module usb_se0_width_classifier_bench;
   localparam logic [`ADDR_W-1:0] A_STATUS = {2'b00, `IDX_STATUS, 2'b00};
   localparam logic [`ADDR_W-1:0] A_CTRL = {2'b00, `IDX_CTRL, 2'b00};
   localparam logic [`ADDR_W-1:0] A_TOKEN = {2'b00, `IDX_TOKEN, 2'b00};
   localparam logic [`ADDR_W-1:0] A_IEN = {2'b00, `IDX_IEN, 2'b00};
   localparam logic [`ADDR_W-1:0] A_ISTAT = {2'b00, `IDX_ISTAT, 2'b00};
   localparam logic [`ADDR_W-1:0] A_IMASK = {2'b00, `IDX_IMASK, 2'b00};
   localparam logic [`ADDR_W-1:0] A_BAD = 12'h0a0;

   logic clk, rst_n, clk_en, se0, rx_active, token_end, token_dir_in, data_end;
   logic [`ADDR_W-1:0] awaddr, araddr;
   logic [31:0] wdata, rdata, mask, d;
   logic [3:0] wstrb;
   logic [1:0] bresp, rresp, r;
   logic awvalid, awready, wvalid, wready, bvalid, bready;
   logic arvalid, arready, rvalid, rready, irq;
   int bad_count;
   int tests_run;

   // device under test with a short suspend time
   usb_se0_width_classifier #(.SUSP_CYCLES(2000)) uut (
      .clk(clk), .rst_n(rst_n), .clk_en(clk_en), .se0(se0), .rx_active(rx_active),
      .token_end(token_end), .token_dir_in(token_dir_in), .data_end(data_end),
      .awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata),
      .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
      .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready),
      .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready), .irq(irq)
   );

   // host on the bus side
   usb_host_model host (
      .clk(clk), .se0(se0), .rx_active(rx_active), .token_end(token_end),
      .token_dir_in(token_dir_in), .data_end(data_end)
   );

   // 50 mhz clock
   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end

   task automatic give_verdict();
      $display("comparisons %0d mismatches %0d", tests_run, bad_count);
      if (bad_count == 0 && tests_run > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask : give_verdict

   task automatic check_val(input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp) begin
         bad_count++;
         $display("MISMATCH at %0t ns: got %h expected %h", $time, got, exp);
      end
   endtask : check_val

   task automatic timed_out();
      $display("wait limit ran out at %0t ns", $time);
      bad_count++;
      give_verdict();
   endtask : timed_out

   // write: address and data offered together, each released when taken
   task automatic axi_write(input logic [`ADDR_W-1:0] a, input logic [31:0] v,
                            output logic [1:0] resp);
      int n;
      awaddr <= a;
      wdata <= v;
      wstrb <= 4'hf;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      for (n = 0; n < 40; n++) begin
         @(posedge clk);
         if (awvalid && awready) awvalid <= 1'b0;
         if (wvalid && wready) wvalid <= 1'b0;
         if (bvalid) break;
      end
      if (n == 40) timed_out();
      resp = bresp;
   endtask : axi_write

   task automatic axi_read(input logic [`ADDR_W-1:0] a, output logic [31:0] v,
                           output logic [1:0] resp);
      int n;
      araddr <= a;
      arvalid <= 1'b1;
      for (n = 0; n < 40; n++) begin
         @(posedge clk);
         if (arvalid && arready) arvalid <= 1'b0;
         if (rvalid) break;
      end
      if (n == 40) timed_out();
      v = rdata;
      resp = rresp;
   endtask : axi_read

   task automatic wr(input logic [`ADDR_W-1:0] a, input logic [31:0] v);
      logic [1:0] resp;
      axi_write(a, v, resp);
      `CHECK(resp, `RESP_OKAY);
   endtask : wr

   task automatic rd_chk(input logic [`ADDR_W-1:0] a, input logic [31:0] exp);
      logic [31:0] v;
      logic [1:0] resp;
      axi_read(a, v, resp);
      `CHECK(resp, `RESP_OKAY);
      `CHECK(v, exp);
   endtask : rd_chk

   // one bus event, then flags and interrupt line checked and cleared
   task automatic run_case(input int kind, input logic dir_in, input int w, input int extra,
                           input logic [31:0] e_istat, input logic [31:0] e_status,
                           input logic [31:0] e_token);
      host.packet(kind, dir_in, w);
      repeat (3 + extra) @(posedge clk);
      `CHECK(irq, |(e_istat & mask));
      rd_chk(A_ISTAT, e_istat);
      rd_chk(A_STATUS, e_status);
      rd_chk(A_TOKEN, e_token);
      wr(A_ISTAT, 32'hff);
      wr(A_STATUS, 32'hff);
      wr(A_TOKEN, 32'hff);
      `CHECK(irq, 1'b0);
   endtask : run_case

   // idle bus until the suspend interrupt shows, bounded
   task automatic wait_suspend();
      int n;
      for (n = 0; n < 2600; n++) begin
         @(posedge clk);
         if (irq === 1'b1) break;
      end
      if (n == 2600) timed_out();
      rd_chk(A_ISTAT, 32'h08);
      rd_chk(A_IEN, 32'h20);
      wr(A_ISTAT, 32'hff);
   endtask : wait_suspend

   // main sequence
   initial begin
      bad_count = 0;
      tests_run = 0;
      mask = 32'h0;
      rst_n = 1'b0;
      clk_en = 1'b1;
      awaddr = '0;
      araddr = '0;
      wdata = 32'h0;
      wstrb = 4'h0;
      awvalid = 1'b0;
      wvalid = 1'b0;
      arvalid = 1'b0;
      bready = 1'b1;
      rready = 1'b1;
      repeat (10) @(posedge clk);
      rst_n <= 1'b1;
      @(posedge clk);
      rd_chk(A_CTRL, 32'h0);
      rd_chk(A_IEN, 32'h50);
      rd_chk(A_ISTAT, 32'h0);
      rd_chk(A_IMASK, 32'h0);
      rd_chk(A_TOKEN, 32'h0);
      rd_chk(A_STATUS, 32'h0);
      axi_write(A_BAD, 32'hff, r);
      `CHECK(r, `RESP_SLVERR);
      axi_read(A_BAD, d, r);
      `CHECK(r, `RESP_SLVERR);
      `CHECK(d, 32'h0);
      wr(A_IEN, 32'hff);
      rd_chk(A_IEN, 32'h50);
      run_case(0, 1'b0, 140, 0, 32'h0, 32'h0, 32'h0);
      wr(A_CTRL, 32'hc0);
      rd_chk(A_CTRL, 32'hc0);
      mask = 32'h3f;
      wr(A_IMASK, mask);
      rd_chk(A_IMASK, 32'h3f);
      run_case(1, 1'b1, 50, 0, 32'h01, 32'h0, 32'h80);
      run_case(1, 1'b0, 25, 0, 32'h02, 32'h0, 32'h80);
      run_case(1, 1'b1, 24, 520, 32'h20, 32'h04, 32'h0);
      run_case(2, 1'b0, 133, 0, 32'h0, 32'h01, 32'h0);
      run_case(2, 1'b0, 20, 520, 32'h20, 32'h04, 32'h0);
      run_case(0, 1'b0, 24, 0, 32'h0, 32'h0, 32'h0);
      run_case(0, 1'b0, 100, 0, 32'h0, 32'h0, 32'h0);
      // a reset-length se0 while the clock enable is low leaves no trace
      clk_en <= 1'b0;
      host.packet(0, 1'b0, 140);
      clk_en <= 1'b1;
      repeat (3) @(posedge clk);
      rd_chk(A_ISTAT, 32'h0);
      rd_chk(A_STATUS, 32'h0);
      run_case(0, 1'b0, 134, 0, 32'h04, 32'h0, 32'h0);
      run_case(1, 1'b1, 140, 0, 32'h04, 32'h0, 32'h0);
      run_case(2, 1'b0, 140, 0, 32'h04, 32'h0, 32'h0);
      mask = 32'h3e;
      wr(A_IMASK, mask);
      run_case(1, 1'b1, 50, 0, 32'h01, 32'h0, 32'h80);
      mask = 32'h3f;
      wr(A_IMASK, mask);
      wait_suspend();
      host.activity(4);
      repeat (3) @(posedge clk);
      rd_chk(A_ISTAT, 32'h10);
      rd_chk(A_IEN, 32'h50);
      wr(A_ISTAT, 32'hff);
      wait_suspend();
      run_case(0, 1'b0, 10, 0, 32'h04, 32'h0, 32'h0);
      give_verdict();
   end
endmodule : usb_se0_width_classifier_bench
